// file: sadc_pkg.sv
package sadc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_BUF_CTL = 8'hB2;
  localparam logic [7:0] OFF_CFG = 8'hBC;
  localparam logic [7:0] OFF_PWR = 8'hDF;
  localparam logic [7:0] OFF_RUN_CTL = 8'hE8;

  localparam logic [7:0] RST_BUF_CTL = 8'h00;
  localparam logic [7:0] RST_CFG = 8'hF8;
  localparam logic [3:0] RST_PWR = 4'hF;
  localparam logic [7:0] RST_RUN_CTL = 8'h00;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CM_BUF_BIT = 0;
  localparam int DIV_MSB = 7;
  localparam int DIV_LSB = 3;
  localparam int EIGHT_BIT = 2;
  localparam int TRACK_BIT = 1;
  localparam int GAIN_BIT = 0;
  localparam int ENABLE_BIT = 7;
  localparam int BURST_BIT = 6;
  localparam int BUSY_BIT = 4;
  localparam int SOC_MSB = 2;
  localparam int SOC_LSB = 0;
  localparam int PWR_MSB = 3;
  localparam int PWR_LSB = 0;

  // ----------------------------------------------------------------
  // Start-of-conversion source codes
  // ----------------------------------------------------------------
  localparam logic [2:0] SOC_BUSY_WR = 3'h0;
  localparam logic [2:0] SOC_TMR0 = 3'h1;
  localparam logic [2:0] SOC_TMR2 = 3'h2;
  localparam logic [2:0] SOC_TMR3 = 3'h3;
  localparam logic [2:0] SOC_PIN = 3'h4;

  // ----------------------------------------------------------------
  // Timing counts
  // ----------------------------------------------------------------
  localparam logic [2:0] TRACK_DELAY_SAR = 3'h4;
  localparam logic [2:0] PWR_SCALE_SHIFT = 3'h3;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PWRUP = 2'b01,
    ST_TRACK = 2'b10,
    ST_CONV = 2'b11
  } sadc_state_t;

  typedef struct packed {
    logic [4:0] sar_clk_div;
    logic eight_bit_sel;
    logic track_delay_sel;
    logic pga_gain_sel;
  } sadc_cfg_t;

  typedef struct packed {
    logic cm_buffer_on;
    logic eight_bit_mode;
    logic pga_gain_one;
    logic tracking;
    logic burst_mode;
  } sadc_analog_t;

endpackage

// file: sadc_pin_sync.sv
module sadc_pin_sync (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic pin_in,
  output logic level_r,
  output logic rise_r
);

  logic q1_r;
  logic q2_r;
  logic q3_r;
  logic agree;

  // Level only moves once two late stages agree
  assign agree = (q2_r == q3_r);

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      q1_r <= 1'b0;
      q2_r <= 1'b0;
      q3_r <= 1'b0;
      level_r <= 1'b0;
      rise_r <= 1'b0;
    end else begin
      q1_r <= pin_in;
      q2_r <= q1_r;
      q3_r <= q2_r;
      if (agree) begin
        level_r <= q3_r;
      end
      rise_r <= agree && q3_r && !level_r;
    end
  end

endmodule

// file: sadc_sar_div.sv
module sadc_sar_div (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic run,
  input wire logic src_tick,
  input wire logic [4:0] div,
  output logic sar_tick_r
);

  logic [4:0] cnt_r;
  logic wrap;

  assign wrap = (cnt_r >= div);

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      cnt_r <= 5'h00;
      sar_tick_r <= 1'b0;
    end else if (!run) begin
      // Restart from zero so the first period after enable is full
      cnt_r <= 5'h00;
      sar_tick_r <= 1'b0;
    end else if (src_tick) begin
      cnt_r <= wrap ? 5'h00 : cnt_r + 5'h01;
      sar_tick_r <= wrap;
    end else begin
      sar_tick_r <= 1'b0;
    end
  end

endmodule

// file: sadc_top.sv
// Functional notes
// - Buffer control bit 0 switches the common-mode buffer off or on.
// - SAR clock equals source clock divided by divider field plus one.
// - Source clock is system clock, or high-frequency oscillator in burst.
// - Configuration bit 2 set selects 8-bit, clear selects normal resolution.
// - Track bit clear: conversion starts right at the start event.
// - Track bit set: conversion starts four SAR clocks after the event.
// - Input keeps tracking during the four-cycle delay, converts afterwards.
// - Gain bit clear gives gain 0.5, set gives gain 1.
// - Burst control selects burst operation or single conversions.
// - Three-bit source field picks the start event; 000 is busy write.
// - Delayed tracking adds four SAR clocks to the burst power-up delay.
//
// The strobed register port was decided locally.
module sadc_top (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic hfosc_tick,
  input wire logic tmr0_ovf,
  input wire logic tmr2_ovf,
  input wire logic tmr3_ovf,
  input wire logic conv_start_pin,
  input wire logic conv_done,
  output logic sar_clock,
  output logic conv_start,
  output logic converting,
  output sadc_pkg::sadc_analog_t analog_ctl
);

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [7:0] cfg_r;
  logic buf_on_r;
  logic [3:0] pwr_r;
  logic enable_r;
  logic burst_r;
  logic [2:0] soc_sel_r;
  logic [7:0] rdata_r;

  // ----------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------
  sadc_pkg::sadc_state_t state_r;
  sadc_pkg::sadc_state_t state_nxt;
  sadc_pkg::sadc_cfg_t held_r;
  sadc_pkg::sadc_cfg_t held_nxt;
  sadc_pkg::sadc_cfg_t live_cfg;
  sadc_pkg::sadc_cfg_t act_cfg;
  logic held_burst_r;
  logic held_burst_nxt;
  logic [6:0] pwr_cnt_r;
  logic [6:0] pwr_cnt_nxt;
  logic [2:0] trk_cnt_r;
  logic [2:0] trk_cnt_nxt;
  logic start_r;
  logic start_nxt;
  sadc_pkg::sadc_analog_t analog_r;
  sadc_pkg::sadc_analog_t analog_nxt;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire hit_cfg = (reg_addr == sadc_pkg::OFF_CFG);
  wire hit_buf = (reg_addr == sadc_pkg::OFF_BUF_CTL);
  wire hit_pwr = (reg_addr == sadc_pkg::OFF_PWR);
  wire hit_run = (reg_addr == sadc_pkg::OFF_RUN_CTL);
  wire wr_cfg = reg_wr && hit_cfg;
  wire wr_buf = reg_wr && hit_buf;
  wire wr_pwr = reg_wr && hit_pwr;
  wire wr_run = reg_wr && hit_run;
  wire busy = (state_r != sadc_pkg::ST_IDLE);

  // Writing one to the busy bit is a trigger, not stored state
  wire busy_wr_one = wr_run && reg_wdata[sadc_pkg::BUSY_BIT];

  // ----------------------------------------------------------------
  // Written field values
  // ----------------------------------------------------------------
  // Fields land at the write edge; a busy write in the same byte still
  // starts under the old enable, burst and source settings
  wire wdata_buf_on = reg_wdata[sadc_pkg::CM_BUF_BIT];
  wire [3:0] wdata_pwr = reg_wdata[sadc_pkg::PWR_MSB:sadc_pkg::PWR_LSB];
  wire wdata_enable = reg_wdata[sadc_pkg::ENABLE_BIT];
  wire wdata_burst = reg_wdata[sadc_pkg::BURST_BIT];
  wire [2:0] wdata_soc_sel = reg_wdata[sadc_pkg::SOC_MSB:sadc_pkg::SOC_LSB];

  // ----------------------------------------------------------------
  // Status readback
  // ----------------------------------------------------------------
  // Busy reads the sequencer itself, so an abort shows at once
  wire [7:0] run_rd = {enable_r,
                       burst_r,
                       1'b0,
                       busy,
                       1'b0,
                       soc_sel_r};
  wire [7:0] rd_mux = hit_cfg ? cfg_r :
                      hit_buf ? {7'h00, buf_on_r} :
                      hit_pwr ? {4'h0, pwr_r} :
                      hit_run ? run_rd :
                      sadc_pkg::RD_UNMAPPED;

  // ----------------------------------------------------------------
  // Start-of-conversion sources
  // ----------------------------------------------------------------
  // Pin edge shows about four cycles late through the synchroniser
  logic pin_rise;

  sadc_pin_sync u_pin_sync (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .pin_in(conv_start_pin),
    .level_r(),
    .rise_r(pin_rise)
  );

  // Reserved source codes never start a conversion
  wire soc_event = (soc_sel_r == sadc_pkg::SOC_BUSY_WR) ? busy_wr_one :
                   (soc_sel_r == sadc_pkg::SOC_TMR0) ? tmr0_ovf :
                   (soc_sel_r == sadc_pkg::SOC_TMR2) ? tmr2_ovf :
                   (soc_sel_r == sadc_pkg::SOC_TMR3) ? tmr3_ovf :
                   (soc_sel_r == sadc_pkg::SOC_PIN) ? pin_rise :
                   1'b0;

  // ----------------------------------------------------------------
  // Clock source and SAR clock divider
  // ----------------------------------------------------------------
  assign live_cfg = sadc_pkg::sadc_cfg_t'(cfg_r);
  // Held copy steers timing while a conversion runs
  assign act_cfg = busy ? held_r : live_cfg;
  wire act_burst = busy ? held_burst_r : burst_r;

  // System clock ticks every cycle; oscillator ticks arrive as enables
  // Oscillator ticks must be one-cycle pulses in this clock domain
  wire src_tick = act_burst ? hfosc_tick : 1'b1;

  logic sar_tick;

  sadc_sar_div u_sar_div (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .run(enable_r),
    .src_tick(src_tick),
    .div(act_cfg.sar_clk_div),
    .sar_tick_r(sar_tick)
  );

  // ----------------------------------------------------------------
  // Power-up and tracking counters
  // ----------------------------------------------------------------
  // Power-up wait is eight source ticks per step of the time field
  wire [6:0] pwr_load = 7'({pwr_r, 3'b000});
  wire pwr_zero = (pwr_cnt_r == 7'h00);
  wire trk_last = (trk_cnt_r == sadc_pkg::TRACK_DELAY_SAR - 3'h1);

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    held_nxt = held_r;
    held_burst_nxt = held_burst_r;
    pwr_cnt_nxt = pwr_cnt_r;
    trk_cnt_nxt = trk_cnt_r;
    start_nxt = 1'b0;
    unique case (state_r)
      sadc_pkg::ST_IDLE: begin
        if (enable_r && soc_event) begin
          held_nxt = live_cfg;
          held_burst_nxt = burst_r;
          trk_cnt_nxt = 3'h0;
          pwr_cnt_nxt = pwr_load;
          if (burst_r) begin
            state_nxt = sadc_pkg::ST_PWRUP;
          end else if (live_cfg.track_delay_sel) begin
            state_nxt = sadc_pkg::ST_TRACK;
          end else begin
            state_nxt = sadc_pkg::ST_CONV;
            start_nxt = 1'b1;
          end
        end
      end
      sadc_pkg::ST_PWRUP: begin
        if (pwr_zero) begin
          if (held_r.track_delay_sel) begin
            // Delayed tracking stretches power-up by four SAR clocks
            state_nxt = sadc_pkg::ST_TRACK;
          end else begin
            state_nxt = sadc_pkg::ST_CONV;
            start_nxt = 1'b1;
          end
        end else if (src_tick) begin
          pwr_cnt_nxt = pwr_cnt_r - 7'h01;
        end
      end
      sadc_pkg::ST_TRACK: begin
        // Counts SAR ticks, so the delay scales with the divider
        if (sar_tick) begin
          if (trk_last) begin
            state_nxt = sadc_pkg::ST_CONV;
            start_nxt = 1'b1;
          end else begin
            trk_cnt_nxt = trk_cnt_r + 3'h1;
          end
        end
      end
      sadc_pkg::ST_CONV: begin
        if (conv_done) begin
          state_nxt = sadc_pkg::ST_IDLE;
        end
      end
    endcase
    // Disable aborts any conversion in flight
    // Held settings stay stale until the next start reloads them
    if (!enable_r) begin
      state_nxt = sadc_pkg::ST_IDLE;
      start_nxt = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Analog control word
  // ----------------------------------------------------------------
  // Registered so the analog core sees clean levels
  always_comb begin
    analog_nxt.cm_buffer_on = buf_on_r;
    analog_nxt.eight_bit_mode = act_cfg.eight_bit_sel;
    analog_nxt.pga_gain_one = act_cfg.pga_gain_sel;
    // Sampler stays on the input until the conversion actually starts
    analog_nxt.tracking = (state_nxt != sadc_pkg::ST_CONV);
    analog_nxt.burst_mode = act_burst;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      cfg_r <= sadc_pkg::RST_CFG;
      buf_on_r <= sadc_pkg::RST_BUF_CTL[sadc_pkg::CM_BUF_BIT];
      pwr_r <= sadc_pkg::RST_PWR;
      enable_r <= sadc_pkg::RST_RUN_CTL[sadc_pkg::ENABLE_BIT];
      burst_r <= sadc_pkg::RST_RUN_CTL[sadc_pkg::BURST_BIT];
      soc_sel_r <= sadc_pkg::RST_RUN_CTL[sadc_pkg::SOC_MSB:sadc_pkg::SOC_LSB];
      rdata_r <= sadc_pkg::RD_UNMAPPED;
    end else begin
      if (wr_cfg) begin
        cfg_r <= reg_wdata;
      end
      if (wr_buf) begin
        // Upper bits have no storage, writes there are dropped
        buf_on_r <= wdata_buf_on;
      end
      if (wr_pwr) begin
        pwr_r <= wdata_pwr;
      end
      if (wr_run) begin
        enable_r <= wdata_enable;
        burst_r <= wdata_burst;
        soc_sel_r <= wdata_soc_sel;
      end
      rdata_r <= reg_rd ? rd_mux : sadc_pkg::RD_UNMAPPED;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state_r <= sadc_pkg::ST_IDLE;
      held_r <= sadc_pkg::sadc_cfg_t'(sadc_pkg::RST_CFG);
      held_burst_r <= 1'b0;
      pwr_cnt_r <= 7'h00;
      trk_cnt_r <= 3'h0;
      start_r <= 1'b0;
      analog_r <= '0;
    end else begin
      state_r <= state_nxt;
      held_r <= held_nxt;
      held_burst_r <= held_burst_nxt;
      pwr_cnt_r <= pwr_cnt_nxt;
      trk_cnt_r <= trk_cnt_nxt;
      start_r <= start_nxt;
      analog_r <= analog_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata = rdata_r;
  assign sar_clock = sar_tick;
  assign conv_start = start_r;
  assign converting = (state_r == sadc_pkg::ST_CONV);
  assign analog_ctl = analog_r;

endmodule

// file: sadc_chk.sv
module sadc_chk (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic conv_done,
  input wire logic sar_clock,
  input wire logic conv_start,
  input wire logic converting,
  input wire sadc_pkg::sadc_analog_t analog_ctl
);
  // ----------------------------------------------------------------
  // Shadow copies of the written registers
  // ----------------------------------------------------------------
  logic [7:0] cfg_r;
  logic buf_r;
  logic en_r;
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      cfg_r <= sadc_pkg::RST_CFG;
      buf_r <= 1'b0;
      en_r <= 1'b0;
    end else if (reg_wr) begin
      if (reg_addr == sadc_pkg::OFF_CFG) cfg_r <= reg_wdata;
      if (reg_addr == sadc_pkg::OFF_BUF_CTL) buf_r <= reg_wdata[0];
      if (reg_addr == sadc_pkg::OFF_RUN_CTL) en_r <= reg_wdata[7];
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  cfg_read_a: assert property (
    reg_rd && reg_addr == sadc_pkg::OFF_CFG |=> reg_rdata == $past(cfg_r))
    else $error("configuration readback wrong");
  buf_read_a: assert property (
    reg_rd && reg_addr == sadc_pkg::OFF_BUF_CTL |=> reg_rdata == {7'h00, $past(buf_r)})
    else $error("buffer control readback wrong");
  cm_live_a: assert property ($stable(buf_r) |-> analog_ctl.cm_buffer_on == buf_r)
    else $error("buffer enable output wrong");
  sar_off_a: assert property (!en_r && !$past(en_r) |-> !sar_clock)
    else $error("sar clock while disabled");
  start_pulse_a: assert property (conv_start |=> !conv_start)
    else $error("start pulse too long");
  start_conv_a: assert property (conv_start |-> converting)
    else $error("start without converting");
  track_hold_a: assert property (converting |-> !analog_ctl.tracking)
    else $error("tracking during conversion");
  cfg_hold_a: assert property (
    converting && $past(converting) |-> $stable(analog_ctl.eight_bit_mode)
      && $stable(analog_ctl.pga_gain_one))
    else $error("settings moved during conversion");
  done_idle_a: assert property (converting && conv_done |=> !converting)
    else $error("conversion did not end");

  cover property (conv_start);
  cover property (converting && conv_done);
  cover property (sar_clock && en_r);
endmodule

// file: sadc_top_test.sv
module sadc_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] A_CFG = sadc_pkg::OFF_CFG;
  localparam logic [7:0] A_BUF = sadc_pkg::OFF_BUF_CTL;
  localparam logic [7:0] A_PWR = sadc_pkg::OFF_PWR;
  localparam logic [7:0] A_RUN = sadc_pkg::OFF_RUN_CTL;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic hfosc_tick = 1'b0;
  // Timer 0, timer 2, timer 3, pin
  logic [3:0] trig = 4'h0;
  logic conv_done = 1'b0;
  logic sar_clock;
  logic conv_start;
  logic converting;
  sadc_pkg::sadc_analog_t analog_ctl;
  int error_cnt = 0;
  int n_tests = 0;
  int cyc;
  int sar_n;
  int trk_lo;
  int p;
  logic [7:0] rd_v;

  sadc_top i_sadc_top (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .hfosc_tick(hfosc_tick), .tmr0_ovf(trig[0]), .tmr2_ovf(trig[1]), .tmr3_ovf(trig[2]),
    .conv_start_pin(trig[3]), .conv_done(conv_done), .sar_clock(sar_clock),
    .conv_start(conv_start), .converting(converting), .analog_ctl(analog_ctl));

  initial forever #5 clk_sys = ~clk_sys;
  // Oscillator tick every second cycle, so burst timing differs visibly
  always @(posedge clk_sys) hfosc_tick <= ~hfosc_tick;

  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    n_tests++;
    if (exp !== got) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cnt(string what, int exp, int got);
    n_tests++;
    if (exp != got) begin
      error_cnt++;
      $display("mismatch %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd_chk(string what, logic [7:0] a, logic [7:0] exp);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(what, exp, reg_rdata);
  endtask
  // Entered at a rising edge; counts cycles and sar pulses up to the start
  task automatic wait_start();
    sar_n = 0;
    trk_lo = 0;
    for (cyc = 0; cyc < 300; cyc++) begin
      #1;
      if (conv_start === 1'b1) return;
      if (sar_clock === 1'b1) sar_n++;
      if (analog_ctl.tracking !== 1'b1) trk_lo++;
      @(posedge clk_sys);
    end
    error_cnt++;
    give_verdict();
  endtask
  task automatic end_conv();
    @(posedge clk_sys);
    conv_done <= 1'b1;
    @(posedge clk_sys);
    conv_done <= 1'b0;
    #1;
    chk("converting", 8'h00, {7'h00, converting});
  endtask
  task automatic period();
    p = 0;
    for (int i = 0; i < 200; i++) begin
      @(posedge clk_sys);
      #1;
      if (p > 0) p++;
      if (sar_clock === 1'b1) begin
        if (p > 1) begin
          p = p - 1;
          return;
        end
        p = 1;
      end
    end
    error_cnt++;
    give_verdict();
  endtask

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk_sys);
    rst_b <= 1'b1;
    rd_chk("cfg", A_CFG, 8'hF8);
    rd_chk("buf", A_BUF, 8'h00);
    rd_chk("pwr", A_PWR, 8'h0F);
    rd_chk("run", A_RUN, 8'h00);
    rd_chk("unmapped", 8'h55, 8'h00);
    $display("test reset done");
    wr(A_PWR, 8'h00);
    wr(A_BUF, 8'h01);
    rd_chk("buf", A_BUF, 8'h01);
    wr(A_CFG, 8'h05);
    rd_chk("cfg", A_CFG, 8'h05);
    // Enable first: a busy write starts only under an enable already set
    wr(A_RUN, 8'h80);
    wr(A_RUN, 8'h90);
    wait_start();
    cnt("start delay", 0, cyc);
    wr(A_CFG, 8'h00);
    #1;
    chk("analog", 8'h1C, {3'h0, analog_ctl});
    rd_chk("run busy", A_RUN, 8'h90);
    end_conv();
    rd_chk("run idle", A_RUN, 8'h80);
    $display("test normal track done");
    wr(A_CFG, 8'h02);
    wr(A_RUN, 8'h90);
    wait_start();
    cnt("track pulses", 4, sar_n);
    cnt("early convert", 0, trk_lo);
    chk("analog", 8'h10, {3'h0, analog_ctl});
    end_conv();
    $display("test delayed track done");
    wr(A_CFG, 8'h10);
    wr(A_RUN, 8'h90);
    wait_start();
    period();
    cnt("sar period", 3, p);
    end_conv();
    // Burst must be set before the busy write that uses it
    wr(A_RUN, 8'hC0);
    wr(A_RUN, 8'hD0);
    wait_start();
    chk("analog", 8'h11, {3'h0, analog_ctl});
    period();
    cnt("burst period", 6, p);
    end_conv();
    wr(A_PWR, 8'h01);
    wr(A_CFG, 8'h02);
    wr(A_RUN, 8'hD0);
    wait_start();
    cnt("burst delay", 1, int'(cyc >= 24 && cyc <= 25));
    end_conv();
    $display("test clocks done");
    wr(A_CFG, 8'h00);
    for (int k = 1; k < 5; k++) begin
      wr(A_RUN, 8'h80 | 8'(k));
      trig[k-1] <= 1'b1;
      @(posedge clk_sys);
      if (k < 4) trig[k-1] <= 1'b0;
      wait_start();
      trig <= 4'h0;
      end_conv();
    end
    wr(A_RUN, 8'h95);
    trig <= 4'hF;
    repeat (10) @(posedge clk_sys);
    trig <= 4'h0;
    #1;
    chk("reserved source", 8'h00, {7'h00, converting});
    $display("test sources done");
    give_verdict();
  end
endmodule

bind sadc_top sadc_chk i_sadc_chk (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .conv_done(conv_done), .sar_clock(sar_clock), .conv_start(conv_start),
  .converting(converting), .analog_ctl(analog_ctl));
